/* File: core/gpio_dual_port.sv */
// Summary of operation
// [RULE1] four-bit two-way port b; every pin is an input after reset
// [RULE2] reset sets every port b output latch bit to one
// [RULE3] reset clears port b direction and select; direction one means output
// [RULE4] a port b select bit of one routes the pin to its peripheral
// [RULE5] port b select bits: timer clock and irq a, irq b, flip-flop a, b
// [RULE6] software must not read-modify-write direction or select registers
// [RULE7] port c pins 0 to 5 are two-way, inputs at reset, latch one
// [RULE8] reset clears direction and select of port c pins 0 to 5
// [RULE9] port c pins 6 and 7 are open drain; latch and direction reset one
// [RULE10] port c select bits 0, 2, 3, 5: tx0, clock0, tx1, clock1
// [RULE11] receive pins have no select bit and always feed the receivers
// [RULE12] open-drain bits: tx0, tx1, two serial-bus pins; one means open drain
// [RULE13] for the low-frequency oscillator software sets directions 11, latch 00 or 10
// [RULE14] data register reads return pin levels, writes update the latch
// [RULE15] a function output drives only with select and direction both one
//
// Decided for this implementation: the Wishbone register port.
`include "gpio_defs.svh"

module gpio_dual_port (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [`GP_WB_DW-1:0] WB_DAT_I,
    output logic [`GP_WB_DW-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // port b pads
    input wire logic [`GP_PB_W-1:0] PB_IN,
    output logic [`GP_PB_W-1:0] PB_OUT,
    output logic [`GP_PB_W-1:0] PB_OE,
    // port c pads
    input wire logic [`GP_PC_W-1:0] PC_IN,
    output logic [`GP_PC_W-1:0] PC_OUT,
    output logic [`GP_PC_W-1:0] PC_OE,
    // from timer and serial units
    input wire logic TIMER_FLIPFLOP_OUT_A,
    input wire logic TIMER_FLIPFLOP_OUT_B,
    input wire logic SERIAL_TX_CH0,
    input wire logic SERIAL_TX_CH1,
    input wire logic SERIAL_CLOCK_CH0_OUT,
    input wire logic SERIAL_CLOCK_CH1_OUT,
    // to timer, interrupt and serial units
    output logic TIMER_CLOCK_INPUT,
    output logic EXT_IRQ_A,
    output logic EXT_IRQ_B,
    output logic SERIAL_RX_CH0,
    output logic SERIAL_RX_CH1,
    output logic SERIAL_CLOCK_CH0_IN,
    output logic SERIAL_CLOCK_CH1_IN,
    // open-drain select for the serial-bus pins of another port
    output logic [1:0] SERIAL_BUS_OPEN_DRAIN
);

    gpio_pkg::port_cfg_t pb_cfg;
    gpio_pkg::port_cfg_t pc_cfg;
    gpio_pkg::pin_drive_t pb_drive;
    gpio_pkg::pin_drive_t pc_drive;

    logic [`GP_PB_W-1:0] pb_latch_reg;
    logic [`GP_PB_W-1:0] pb_dir_reg;
    logic [`GP_PB_W-1:0] pb_alt_reg;
    logic [`GP_PC_W-1:0] pc_latch_reg;
    logic [`GP_PC_W-1:0] pc_dir_reg;
    logic [`GP_PC_W-1:0] pc_alt_reg;
    logic [`GP_OD_W-1:0] od_reg;

    logic [`GP_PB_W-1:0] pb_level;
    logic [`GP_PC_W-1:0] pc_level;

    logic ack_reg;
    logic [`GP_WB_DW-1:0] rdata_reg;
    logic [`GP_WB_DW-1:0] rdata_next;
    logic req;
    logic wr_lo;
    logic [7:0] idx;
    logic [7:0] wbyte;

    logic [`GP_PC_W-1:0] pc_od;
    logic [`GP_PC_W-1:0] pc_alt_data;
    logic [`GP_PB_W-1:0] pb_alt_data;

    // bus request decode; one new request per idle cycle
    assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wr_lo = req & WB_WE_I & WB_SEL_I[0];
    assign idx = WB_ADR_I[9:2];
    assign wbyte = WB_DAT_I[7:0];

    // acknowledge one cycle after the request is seen, drop it the next
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // port b output latch
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pb_latch_reg <= `GP_PB_LATCH_RST; // RULE2
        end else if (wr_lo && idx == `GP_IDX_PB_DATA) begin
            pb_latch_reg <= wbyte[`GP_PB_W-1:0]; // RULE14
        end
    end

    // port b direction, write only
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pb_dir_reg <= `GP_PB_DIR_RST; // RULE1 RULE3
        end else if (wr_lo && idx == `GP_IDX_PB_DIR) begin
            pb_dir_reg <= wbyte[`GP_PB_W-1:0];
        end
    end

    // port b function select, write only
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pb_alt_reg <= `GP_PB_ALT_RST; // RULE3
        end else if (wr_lo && idx == `GP_IDX_PB_ALT) begin
            pb_alt_reg <= wbyte[`GP_PB_W-1:0]; // RULE4
        end
    end

    // port c output latch
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pc_latch_reg <= `GP_PC_LATCH_RST; // RULE7 RULE9
        end else if (wr_lo && idx == `GP_IDX_PC_DATA) begin
            pc_latch_reg <= wbyte; // RULE14
        end
    end

    // port c direction, write only
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pc_dir_reg <= `GP_PC_DIR_RST; // RULE8 RULE9
        end else if (wr_lo && idx == `GP_IDX_PC_DIR) begin
            pc_dir_reg <= wbyte;
        end
    end

    // port c function select; only function-capable bits are kept
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pc_alt_reg <= `GP_PC_ALT_RST; // RULE8
        end else if (wr_lo && idx == `GP_IDX_PC_ALT) begin
            pc_alt_reg <= wbyte & `GP_PC_ALT_MASK; // RULE10 RULE11
        end
    end

    // open-drain select, readable
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            od_reg <= `GP_OD_RST; // RULE12
        end else if (wr_lo && idx == `GP_IDX_OD_SEL) begin
            od_reg <= wbyte[`GP_OD_W-1:0]; // RULE12
        end
    end

    // read mux; write-only and unmapped locations read zero
    always_comb begin
        rdata_next = '0;
        unique case (idx)
            `GP_IDX_PB_DATA: rdata_next[`GP_PB_W-1:0] = pb_level; // RULE14
            `GP_IDX_PC_DATA: rdata_next[`GP_PC_W-1:0] = pc_level; // RULE14
            `GP_IDX_OD_SEL: rdata_next[`GP_OD_W-1:0] = od_reg;
            default: rdata_next = '0; // RULE6
        endcase
    end

    // read data held with the acknowledge
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rdata_reg <= '0;
        end else if (req && !WB_WE_I) begin
            rdata_reg <= rdata_next;
        end else if (!req) begin
            rdata_reg <= '0;
        end
    end

    assign WB_DAT_O = rdata_reg;
    assign WB_ACK_O = ack_reg;

    // setup carriers
    assign pb_cfg = '{latch: 8'(pb_latch_reg), dir: 8'(pb_dir_reg), alt: 8'(pb_alt_reg)};
    assign pc_cfg = '{latch: pc_latch_reg, dir: pc_dir_reg, alt: pc_alt_reg};

    // function output values by pin
    always_comb begin
        pb_alt_data = '0;
        pb_alt_data[`GP_PB_TFF_A] = TIMER_FLIPFLOP_OUT_A; // RULE5
        pb_alt_data[`GP_PB_TFF_B] = TIMER_FLIPFLOP_OUT_B; // RULE5
    end

    always_comb begin
        pc_alt_data = '0;
        pc_alt_data[`GP_PC_TX0] = SERIAL_TX_CH0; // RULE10
        pc_alt_data[`GP_PC_SCK0] = SERIAL_CLOCK_CH0_OUT; // RULE10
        pc_alt_data[`GP_PC_TX1] = SERIAL_TX_CH1; // RULE10
        pc_alt_data[`GP_PC_SCK1] = SERIAL_CLOCK_CH1_OUT; // RULE10
    end

    // open drain on port c: fixed on the oscillator pins, selectable on tx
    always_comb begin
        pc_od = `GP_PC_FIXED_OD; // RULE9
        pc_od[`GP_PC_TX0] = od_reg[`GP_OD_TX0]; // RULE12
        pc_od[`GP_PC_TX1] = od_reg[`GP_OD_TX1]; // RULE12
    end

    // port b pad drive
    pin_drive #(
        .W(`GP_PB_W)
    ) u_pb_drive (
        .clk(CLK),
        .rst_b(RST_B),
        .latch(pb_cfg.latch[`GP_PB_W-1:0]),
        .dir(pb_cfg.dir[`GP_PB_W-1:0]),
        .alt(pb_cfg.alt[`GP_PB_W-1:0]),
        .alt_mask(`GP_PB_ALT_OUT_MASK), // RULE15
        .alt_data(pb_alt_data),
        .open_drain(`GP_PB_DIR_RST),
        .pad_out(pb_drive.out[`GP_PB_W-1:0]),
        .pad_oe(pb_drive.oe[`GP_PB_W-1:0])
    );
    assign pb_drive.out[7:`GP_PB_W] = '0;
    assign pb_drive.oe[7:`GP_PB_W] = '0;

    // port c pad drive
    pin_drive #(
        .W(`GP_PC_W)
    ) u_pc_drive (
        .clk(CLK),
        .rst_b(RST_B),
        .latch(pc_cfg.latch),
        .dir(pc_cfg.dir),
        .alt(pc_cfg.alt),
        .alt_mask(`GP_PC_ALT_MASK), // RULE15
        .alt_data(pc_alt_data),
        .open_drain(pc_od),
        .pad_out(pc_drive.out),
        .pad_oe(pc_drive.oe)
    );

    assign PB_OUT = pb_drive.out[`GP_PB_W-1:0];
    assign PB_OE = pb_drive.oe[`GP_PB_W-1:0];
    assign PC_OUT = pc_drive.out;
    assign PC_OE = pc_drive.oe;

    // pin input synchronisers
    pin_sync #(
        .W(`GP_PB_W),
        .RST_VAL(`GP_PB_LATCH_RST)
    ) u_pb_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .raw(PB_IN),
        .level(pb_level)
    );

    pin_sync #(
        .W(`GP_PC_W),
        .RST_VAL(`GP_PC_LATCH_RST)
    ) u_pc_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .raw(PC_IN),
        .level(pc_level)
    );

    // port b input functions, passed only while selected
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            TIMER_CLOCK_INPUT <= 1'b0;
            EXT_IRQ_A <= 1'b0;
            EXT_IRQ_B <= 1'b0;
        end else begin
            TIMER_CLOCK_INPUT <= pb_alt_reg[`GP_PB_TMR_CLK] & pb_level[`GP_PB_TMR_CLK]; // RULE5
            EXT_IRQ_A <= pb_alt_reg[`GP_PB_TMR_CLK] & pb_level[`GP_PB_TMR_CLK]; // RULE5
            EXT_IRQ_B <= pb_alt_reg[`GP_PB_IRQ_B] & pb_level[`GP_PB_IRQ_B]; // RULE4
        end
    end

    // serial inputs: receive always fed, clock input level always fed
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SERIAL_RX_CH0 <= 1'b1;
            SERIAL_RX_CH1 <= 1'b1;
            SERIAL_CLOCK_CH0_IN <= 1'b1;
            SERIAL_CLOCK_CH1_IN <= 1'b1;
        end else begin
            SERIAL_RX_CH0 <= pc_level[`GP_PC_RX0]; // RULE11
            SERIAL_RX_CH1 <= pc_level[`GP_PC_RX1]; // RULE11
            SERIAL_CLOCK_CH0_IN <= pc_level[`GP_PC_SCK0];
            SERIAL_CLOCK_CH1_IN <= pc_level[`GP_PC_SCK1];
        end
    end

    // open-drain select for the serial-bus pins elsewhere
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SERIAL_BUS_OPEN_DRAIN <= '0;
        end else begin
            SERIAL_BUS_OPEN_DRAIN <= od_reg[`GP_OD_BUS_HI:`GP_OD_BUS_LO]; // RULE12
        end
    end

endmodule

/* File: include/gpio_defs.svh */
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// register indices; byte address is four times the index
`define GP_IDX_PB_DATA 8'h18
`define GP_IDX_PC_DATA 8'h19
`define GP_IDX_PB_DIR 8'h1A
`define GP_IDX_PB_ALT 8'h1B
`define GP_IDX_PC_DIR 8'h1C
`define GP_IDX_PC_ALT 8'h1D
`define GP_IDX_OD_SEL 8'h2F

// widths
`define GP_PB_W 4
`define GP_PC_W 8
`define GP_OD_W 4

// reset values
`define GP_PB_LATCH_RST 4'hF
`define GP_PB_DIR_RST 4'h0
`define GP_PB_ALT_RST 4'h0
`define GP_PC_LATCH_RST 8'hFF
`define GP_PC_DIR_RST 8'hC0
`define GP_PC_ALT_RST 8'h00
`define GP_OD_RST 4'h0

// pins that own an alternate output function
`define GP_PB_ALT_OUT_MASK 4'hC
`define GP_PC_ALT_MASK 8'h2D
// pins that are open drain whatever the open-drain register says
`define GP_PC_FIXED_OD 8'hC0

// port b pin positions
`define GP_PB_TMR_CLK 0
`define GP_PB_IRQ_B 1
`define GP_PB_TFF_A 2
`define GP_PB_TFF_B 3
// port c pin positions
`define GP_PC_TX0 0
`define GP_PC_RX0 1
`define GP_PC_SCK0 2
`define GP_PC_TX1 3
`define GP_PC_RX1 4
`define GP_PC_SCK1 5
// open-drain register bit positions
`define GP_OD_TX0 0
`define GP_OD_TX1 1
`define GP_OD_BUS_LO 2
`define GP_OD_BUS_HI 3

// synchroniser depth and wishbone data width
`define GP_SYNC_STAGES 3
`define GP_WB_DW 32

`endif

/* File: include/gpio_pkg.sv */
package gpio_pkg;

    // software-visible setup of one port
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] alt;
    } port_cfg_t;

    // drive of a group of pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

endpackage

/* File: core/pin_sync.sv */
`include "gpio_defs.svh"

module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // raw pins and filtered levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] level
);
    // three stages per bit; a change counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [`GP_SYNC_STAGES-1:0] stage_reg;
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    stage_reg <= '0;
                end else begin
                    stage_reg <= {stage_reg[`GP_SYNC_STAGES-2:0], raw[i]};
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    level[i] <= RST_VAL[i];
                end else if (stage_reg[1] == stage_reg[2]) begin
                    level[i] <= stage_reg[2];
                end
            end
        end
    endgenerate
endmodule

/* File: core/pin_drive.sv */
module pin_drive #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // setup
    input wire logic [W-1:0] latch,
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] alt,
    input wire logic [W-1:0] alt_mask,
    input wire logic [W-1:0] alt_data,
    input wire logic [W-1:0] open_drain,
    // registered pad drive
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe
);
    // per pin: pick port or function value, then apply open drain
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            logic use_alt;
            logic value;
            assign use_alt = alt[i] & dir[i] & alt_mask[i];
            assign value = use_alt ? alt_data[i] : latch[i];
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    pad_out[i] <= 1'b1;
                    pad_oe[i] <= 1'b0;
                end else begin
                    pad_out[i] <= open_drain[i] ? 1'b0 : value;
                    pad_oe[i] <= dir[i] & ~(open_drain[i] & value);
                end
            end
        end
    endgenerate
endmodule

/* File: test/gpio_dual_port_props.sv */
`include "gpio_defs.svh"

module gpio_dual_port_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [`GP_WB_DW-1:0] WB_DAT_I,
    input wire logic [`GP_WB_DW-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // pads and peripheral levels
    input wire logic [`GP_PB_W-1:0] PB_OUT,
    input wire logic [`GP_PB_W-1:0] PB_OE,
    input wire logic [`GP_PC_W-1:0] PC_OUT,
    input wire logic [`GP_PC_W-1:0] PC_OE,
    input wire logic TIMER_CLOCK_INPUT,
    input wire logic EXT_IRQ_A,
    input wire logic SERIAL_RX_CH0,
    input wire logic SERIAL_RX_CH1,
    input wire logic [1:0] SERIAL_BUS_OPEN_DRAIN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic [1:0] od_reg;
    // bus-pin bits of the last accepted open-drain write
    always_ff @(posedge CLK) begin
        if (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
            && WB_ADR_I[9:2] == `GP_IDX_OD_SEL) begin
            od_reg <= WB_DAT_I[3:2];
        end
    end
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_od_write;
        s_take ##0 (WB_WE_I && WB_SEL_I[0] && WB_ADR_I[9:2] == `GP_IDX_OD_SEL);
    endsequence
    // bus handshake and read data
    property p_ack_once;
        s_take |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    property p_dat_quiet;
        !WB_ACK_O |-> WB_DAT_O == '0;
    endproperty
    property p_pb_width;
        WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == `GP_IDX_PB_DATA |-> WB_DAT_O[31:4] == '0;
    endproperty
    property p_wo_read;
        WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == `GP_IDX_PB_DIR |-> WB_DAT_O == '0;
    endproperty
    // pad and peripheral levels
    property p_reset_pins;
        $rose(RST_B) |-> PB_OUT == `GP_PB_LATCH_RST && PB_OE == 4'h0 && PC_OE == 8'h00;
    endproperty
    property p_reset_units;
        $rose(RST_B) |-> SERIAL_RX_CH0 && SERIAL_RX_CH1 && !TIMER_CLOCK_INPUT
            && SERIAL_BUS_OPEN_DRAIN == 2'h0;
    endproperty
    property p_fixed_od;
        (|PC_OE[7:6]) |-> (PC_OE[7:6] & PC_OUT[7:6]) == 2'h0;
    endproperty
    property p_irq_pair;
        TIMER_CLOCK_INPUT == EXT_IRQ_A;
    endproperty
    property p_od_copy;
        s_od_write |-> ##[1:3] (SERIAL_BUS_OPEN_DRAIN == od_reg);
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_dat_quiet: assert property (p_dat_quiet) else $error("read data off ack");
    a_pb_width: assert property (p_pb_width) else $error("port b read too wide");
    a_wo_read: assert property (p_wo_read) else $error("direction read back");
    a_reset_pins: assert property (p_reset_pins) else $error("pads after reset");
    a_reset_units: assert property (p_reset_units) else $error("units after reset");
    a_fixed_od: assert property (p_fixed_od) else $error("pins 6 7 driven high");
    a_irq_pair: assert property (p_irq_pair) else $error("timer clock and irq a differ");
    a_od_copy: assert property (p_od_copy) else $error("bus open drain stale");
endmodule

bind gpio_dual_port gpio_dual_port_props u_props (.CLK, .RST_B, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .PB_OUT, .PB_OE,
    .PC_OUT, .PC_OE, .TIMER_CLOCK_INPUT, .EXT_IRQ_A, .SERIAL_RX_CH0, .SERIAL_RX_CH1,
    .SERIAL_BUS_OPEN_DRAIN);

/* File: test/pin_world.sv */
module pin_world (
    // pad drive from the port block
    input wire logic [3:0] pb_out,
    input wire logic [3:0] pb_oe,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe,
    // levels the outside applies to released pins
    input wire logic [3:0] ext_b,
    input wire logic [7:0] ext_c,
    // resolved pin levels
    output logic [3:0] pb_in,
    output logic [7:0] pc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pin shows the block, a released one the outside level
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
    // receive pins feed back whatever the pin is used for
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
endmodule

/* File: test/gpio_dual_port_tb.sv */
`include "gpio_defs.svh"

module gpio_dual_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0, pb_in, pb_out, pb_oe, xb = 4'h0, od, eb_oe, eb_out, lb;
    logic [31:0] wdat = 32'h0, rdat, q, w, s, rng = 32'h00012CA1;
    logic [7:0] pc_in, pc_out, pc_oe, xc = 8'h00, ec_oe, ec_out, lc, uc, odm;
    logic [5:0] uo = 6'h00;
    logic [6:0] po;
    logic [1:0] bod;
    logic [7:0] idx [0:6] = '{`GP_IDX_PB_DATA, `GP_IDX_PC_DATA, `GP_IDX_PB_DIR,
        `GP_IDX_PB_ALT, `GP_IDX_PC_DIR, `GP_IDX_PC_ALT, `GP_IDX_OD_SEL};
    gpio_pkg::port_cfg_t mb, mc;
    int n_mismatch = 0, n_tests = 0;
    // free-running clock
    always #20 clk = ~clk;
    gpio_dual_port DUT (
        .CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PC_IN(pc_in), .PC_OUT(pc_out),
        .PC_OE(pc_oe), .TIMER_FLIPFLOP_OUT_A(uo[0]), .TIMER_FLIPFLOP_OUT_B(uo[1]),
        .SERIAL_TX_CH0(uo[2]), .SERIAL_TX_CH1(uo[3]), .SERIAL_CLOCK_CH0_OUT(uo[4]),
        .SERIAL_CLOCK_CH1_OUT(uo[5]), .TIMER_CLOCK_INPUT(po[0]), .EXT_IRQ_A(po[1]),
        .EXT_IRQ_B(po[2]), .SERIAL_RX_CH0(po[3]), .SERIAL_RX_CH1(po[4]),
        .SERIAL_CLOCK_CH0_IN(po[5]), .SERIAL_CLOCK_CH1_IN(po[6]),
        .SERIAL_BUS_OPEN_DRAIN(bod));
    pin_world u_world (.pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe),
        .ext_b(xb), .ext_c(xc), .pb_in(pb_in), .pc_in(pc_in));
    // seeded xorshift source
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic wr_en, input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] rd_q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr_en;
        adr <= a;
        wdat <= d;
        sel <= be;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        rd_q = rdat;
        if (k >= 50) begin
            n_mismatch++;
            close_out();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // register write, mirrored into the bench model when byte 0 is enabled
    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [3:0] be);
        wb(1'b1, {i, 2'h0}, d, be, q);
        if (be[0]) begin
            case (i)
                `GP_IDX_PB_DATA: mb.latch[3:0] = d[3:0];
                `GP_IDX_PC_DATA: mc.latch = d[7:0];
                `GP_IDX_PB_DIR: mb.dir[3:0] = d[3:0];
                `GP_IDX_PB_ALT: mb.alt[3:0] = d[3:0];
                `GP_IDX_PC_DIR: mc.dir = d[7:0];
                `GP_IDX_PC_ALT: mc.alt = d[7:0] & `GP_PC_ALT_MASK;
                `GP_IDX_OD_SEL: od = d[3:0];
                default: ;
            endcase
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, {i, 2'h0}, 32'h0, 4'hF, q);
        chk(q, e);
    endtask
    // expected pad drive and pin levels from the model
    task automatic model();
        logic [3:0] ub, vb;
        logic [7:0] vc;
        ub = mb.alt[3:0] & mb.dir[3:0] & `GP_PB_ALT_OUT_MASK;
        vb = (ub & {uo[1], uo[0], 2'h0}) | (~ub & mb.latch[3:0]);
        eb_oe = mb.dir[3:0];
        eb_out = vb & eb_oe;
        uc = mc.alt & mc.dir & `GP_PC_ALT_MASK;
        vc = (uc & {2'h0, uo[5], 1'h0, uo[3], uo[4], 1'h0, uo[2]}) | (~uc & mc.latch);
        odm = `GP_PC_FIXED_OD | {4'h0, od[1], 2'h0, od[0]};
        // an open-drain pin only drives while its value is low
        ec_oe = mc.dir & ~(odm & vc);
        ec_out = vc & ec_oe;
        lb = eb_out | (~eb_oe & xb);
        lc = ec_out | (~ec_oe & xc);
    endtask
    task automatic check_all();
        repeat (8) @(posedge clk);
        model();
        chk({pb_oe, pb_out & pb_oe, pc_oe, pc_out & pc_oe}, {eb_oe, eb_out, ec_oe, ec_out});
        chk({po, bod}, {lc[5], lc[2], lc[4], lc[1], lb[1] & mb.alt[1],
            {2{lb[0] & mb.alt[0]}}, od[3:2]});
        rd(`GP_IDX_PB_DATA, {28'h0, lb});
        rd(`GP_IDX_PC_DATA, {24'h0, lc});
        rd(`GP_IDX_OD_SEL, {28'h0, od});
        rd(`GP_IDX_PB_DIR, 32'h0);
        rd(8'hFF, 32'h0);
    endtask
    // reset, then random register traffic against the model
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        mb = '{latch: 8'h0F, dir: 8'h00, alt: 8'h00};
        mc = '{latch: 8'hFF, dir: 8'hC0, alt: 8'h00};
        od = 4'h0;
        @(posedge clk);
        check_all();
        wb(1'b1, 10'h3FC, 32'hFFFFFFFF, 4'hF, q);
        check_all();
        for (int i = 0; i < 40; i++) begin
            foreach (idx[k]) begin
                w = xs();
                s = xs();
                if (i < 2) begin
                    s[0] = 1'b1;
                    w[7:6] = (idx[k] == `GP_IDX_PC_DATA) ? {1'h0, i[0]} : 2'h3;
                end
                wr(idx[k], w, s[3:0]);
            end
            w = xs();
            xb <= w[3:0];
            xc <= w[11:4];
            uo <= w[17:12];
            check_all();
        end
        close_out();
    end
endmodule
